// ==== meter_irq_device.sv ====
// device end: interrupt cause and enable registers driving the request line
// assumes the host keeps to one access per cycle; event pulses are on i_ref_clk
// events are sampled once per clock, so a pulse that spans no rising edge is lost
// the host clears causes by writing back the complement of what it read
// How it works
// - irq low when any enabled cause set
// - causes stay set until host clears
// - bit 15 set on cycle overrun
// - bit 14 set on cycle done
// - bit 13 set on reactive direction change
// - bit 12 set on real direction change
// - bit 11 set on zero crossing loss
// - bit 10 set on under-voltage
// - bit 9 set on over-voltage
// - bit 8 set on over-current
// - bit 2 set on accumulator overflow
// - bit 1 set on checksum change
// - bit 0 set on imminent supply failure
// - enable bits match cause bit positions
// - host eases dsp load after overrun
// - host reviews configuration after checksum change
// - host saves state on supply failure
// - fundamental disable bit stops fundamental calculations
`include "meter_irq_map.svh"
`timescale 1ns/1ps
`default_nettype none
module meter_irq_device #(
  parameter int WORD_BITS = 16,
  parameter int ADDR_BITS = 8
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  meter_irq_if.device              bus,
  input  wire logic                i_cycle_late,
  input  wire logic                i_dsp_done,
  input  wire logic                i_reactive_dir_change,
  input  wire logic                i_real_dir_change,
  input  wire logic                i_zero_cross_loss,
  input  wire logic                i_low_voltage,
  input  wire logic                i_high_voltage,
  input  wire logic                i_high_current,
  input  wire logic                i_energy_wrap,
  input  wire logic [15:0]         i_config_checksum,
  input  wire logic                i_supply_fail,
  output logic                     o_fundamental_disable
);
  import meter_irq_pkg::*;

  // the carrier fixes both widths; any other value cannot be served
  if (WORD_BITS != $bits(word_t)) begin : g_word_check
    $error("register word width must be 16");
  end
  if (ADDR_BITS != $bits(addr_t)) begin : g_addr_check
    $error("register address width must be 8");
  end
  if (`BIT_CYCLE_LATE >= WORD_BITS) begin : g_cause_check
    $error("cause positions must fit in the register word");
  end
  if (`FUND_DISABLE_BIT > 7) begin : g_mode_check
    $error("mode register holds only eight bits");
  end

  localparam word_t IMPL_MASK = `IMPLEMENTED_BITS;

  typedef struct packed {
    word_t       cause;
    word_t       enable;
    logic [7:0]  mode2;
    logic [15:0] sum_seen;
    logic        sum_valid;
    word_t       rdata;
    logic        rvalid;
    logic        irq_n;
  } dev_state_t;

  // every field clears on reset except irq_n, which starts high; the checksum reference is seeded afresh
  localparam dev_state_t RESET_STATE = '{
    cause:     `CAUSE_RESET,
    enable:    `ENABLE_RESET,
    mode2:     `MODE_CTRL_TWO_RESET,
    sum_seen:  16'h0000,
    sum_valid: 1'b0,
    rdata:     16'h0000,
    rvalid:    1'b0,
    irq_n:     1'b1
  };

  dev_state_t s_q;
  dev_state_t s_d;
  word_t      events;
  // write decode
  logic       wr_cause;
  logic       wr_enable;
  logic       wr_mode;
  // per-bit next values
  word_t      keep;
  word_t      cause_next;
  word_t      enable_next;
  word_t      pending;
  word_t      read_word;

  // one write per cycle; the first matching offset wins
  always_comb begin
    wr_cause  = 1'b0;
    wr_enable = 1'b0;
    wr_mode   = 1'b0;
    if (bus.wr && bus.addr == `IRQ_CAUSE_OFFSET) begin
      wr_cause = 1'b1;
    end else if (bus.wr && bus.addr == `IRQ_ENABLE_OFFSET) begin
      wr_enable = 1'b1;
    end else if (bus.wr && bus.addr == `MODE_CTRL_TWO_OFFSET) begin
      wr_mode = 1'b1;
    end
  end

  always_comb begin
    events = 16'h0000;
    // processing-cycle events
    events[`BIT_CYCLE_LATE]      = i_cycle_late;
    events[`BIT_DSP_DONE]        = i_dsp_done;

    // direction and zero-crossing events
    events[`BIT_REACTIVE_DIR]    = i_reactive_dir_change;
    events[`BIT_REAL_DIR]        = i_real_dir_change;
    events[`BIT_ZERO_CROSS_LOSS] = i_zero_cross_loss;

    // level detectors
    events[`BIT_LOW_VOLTAGE]     = i_low_voltage;
    events[`BIT_HIGH_VOLTAGE]    = i_high_voltage;
    events[`BIT_HIGH_CURRENT]    = i_high_current;

    // accumulator, checksum and supply
    events[`BIT_ENERGY_WRAP]     = i_energy_wrap;
    // first sample after reset only seeds the reference, no false change
    events[`BIT_CONFIG_SUM]      = s_q.sum_valid &&
                                   (i_config_checksum != s_q.sum_seen);
    events[`BIT_SUPPLY_FAIL]     = i_supply_fail;
  end

  // a one written keeps a cause and a zero clears it; no write keeps all
  assign keep = wr_cause ? bus.wdata : 16'hffff;

  // per bit: an event in the clear cycle wins, so no event is ever lost;
  // reserved positions are tied off and can never reach the request line
  for (genvar b = 0; b < WORD_BITS; b++) begin : g_bit
    assign cause_next[b] = IMPL_MASK[b] &
                           (events[b] | (s_q.cause[b] & keep[b]));
    assign enable_next[b] = IMPL_MASK[b] &
                            (wr_enable ? bus.wdata[b] : s_q.enable[b]);
    assign pending[b] = cause_next[b] & enable_next[b];
  end

  // reads see the registers as they stood before this cycle's write
  always_comb begin
    read_word = 16'h0000;
    if (bus.addr == `IRQ_CAUSE_OFFSET) begin
      read_word = s_q.cause;
    end else if (bus.addr == `IRQ_ENABLE_OFFSET) begin
      read_word = s_q.enable;
    end else if (bus.addr == `MODE_CTRL_TWO_OFFSET) begin
      read_word = {8'h00, s_q.mode2};
    end
  end

  always_comb begin
    s_d           = s_q;
    s_d.sum_seen  = i_config_checksum;
    s_d.sum_valid = 1'b1;
    s_d.cause     = cause_next;
    s_d.enable    = enable_next;
    s_d.rvalid    = 1'b0;

    if (wr_mode) begin
      s_d.mode2 = bus.wdata[7:0];
    end

    // rdata holds between reads so a slow host may still pick it up
    if (bus.rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = read_word;
    end

    // the request follows the next state, so it moves on the cause's edge
    s_d.irq_n = ~|pending;
  end

  // one register for all state keeps reset and update in one place
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs come straight from the state register
  assign bus.rdata             = s_q.rdata;
  assign bus.rvalid            = s_q.rvalid;
  assign bus.irq_n             = s_q.irq_n;
  assign o_fundamental_disable = s_q.mode2[`FUND_DISABLE_BIT];
endmodule // meter_irq_device
`default_nettype wire

// ==== meter_irq_host.sv ====
// host end: on a request line read the causes and clear the serviced ones
// assumes the device answers reads one cycle after the request
`include "meter_irq_map.svh"
`timescale 1ns/1ps
`default_nettype none
module meter_irq_host (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  meter_irq_if.host                 bus,
  input  wire logic                 i_auto_service,
  output logic                      o_irq_seen,
  output meter_irq_pkg::word_t      o_last_cause,
  output logic                      o_overrun_alert,
  output logic                      o_checksum_alert,
  output logic                      o_save_state
);
  import meter_irq_pkg::*;

  typedef struct packed {
    host_state_t st;
    logic        irq_n_m;
    logic        irq_n_s;
    logic        wr;
    logic        rd;
    addr_t       addr;
    word_t       wdata;
    word_t       last;
    logic        seen;
    logic        overrun;
    logic        checksum;
    logic        save;
    logic        armed;
    logic [1:0]  hold;
  } host_st_t;

  host_st_t s_q;
  host_st_t s_d;

  always_comb begin
    s_d         = s_q;
    s_d.irq_n_m = bus.irq_n;
    s_d.irq_n_s = s_q.irq_n_m;
    s_d.wr      = 1'b0;
    s_d.rd      = 1'b0;
    s_d.seen    = 1'b0;
    case (s_q.st)
      HOST_IDLE: begin
        if (!s_q.armed) begin
          // unmask every implemented cause once after reset
          s_d.wr    = 1'b1;
          s_d.addr  = `IRQ_ENABLE_OFFSET;
          s_d.wdata = `IMPLEMENTED_BITS;
          s_d.armed = 1'b1;
        end else if (!s_q.irq_n_s && i_auto_service) begin
          s_d.rd   = 1'b1;
          s_d.addr = `IRQ_CAUSE_OFFSET;
          s_d.st   = HOST_READ;
        end
      end
      HOST_READ: begin
        if (bus.rvalid) begin
          s_d.last     = bus.rdata;
          s_d.seen     = 1'b1;
          s_d.overrun  = bus.rdata[`BIT_CYCLE_LATE];
          s_d.checksum = bus.rdata[`BIT_CONFIG_SUM];
          s_d.save     = bus.rdata[`BIT_SUPPLY_FAIL];
          // write zero only where a bit was seen, so new events survive
          s_d.wr    = 1'b1;
          s_d.wdata = ~bus.rdata;
          s_d.hold  = 2'd2;
          s_d.st    = HOST_CLEAR;
        end
      end
      HOST_CLEAR: begin
        // the cleared line needs three edges through the synchroniser,
        // else a stale low level starts a second, empty service
        if (s_q.hold == 2'd0) begin
          s_d.st = HOST_IDLE;
        end else begin
          s_d.hold = s_q.hold - 2'd1;
        end
      end
      default: s_d.st = HOST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_q <= '{st: HOST_IDLE, irq_n_m: 1'b1, irq_n_s: 1'b1, addr: 8'h00,
               wdata: 16'h0000, last: 16'h0000, default: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.wr           = s_q.wr;
  assign bus.rd           = s_q.rd;
  assign bus.addr         = s_q.addr;
  assign bus.wdata        = s_q.wdata;
  assign o_irq_seen       = s_q.seen;
  assign o_last_cause     = s_q.last;
  assign o_overrun_alert  = s_q.overrun;
  assign o_checksum_alert = s_q.checksum;
  assign o_save_state     = s_q.save;
endmodule // meter_irq_host
`default_nettype wire

// ==== meter_irq_if.sv ====
// register port and interrupt line between metering device and host
// assumes one shared clock; host is the only register master
`timescale 1ns/1ps
`default_nettype none
interface meter_irq_if;
  import meter_irq_pkg::*;
  logic  wr;
  logic  rd;
  addr_t addr;
  word_t wdata;
  word_t rdata;
  logic  rvalid;
  logic  irq_n;
  modport device (input wr, input rd, input addr, input wdata,
                  output rdata, output rvalid, output irq_n);
  modport host (output wr, output rd, output addr, output wdata,
                input rdata, input rvalid, input irq_n);
endinterface
`default_nettype wire

// ==== meter_irq_map.svh ====
// register map, field positions, reset values for the meter interrupt flags block
// assumes a 16-bit register port with word offsets as printed
`ifndef METER_IRQ_MAP_SVH
`define METER_IRQ_MAP_SVH
`define IRQ_CAUSE_OFFSET      8'h04
`define IRQ_ENABLE_OFFSET     8'h06
`define MODE_CTRL_TWO_OFFSET  8'h03
`define CAUSE_RESET           16'h0000
`define ENABLE_RESET          16'h0000
`define MODE_CTRL_TWO_RESET   8'h00
`define IMPLEMENTED_BITS      16'hff07
`define FUND_DISABLE_BIT      4
`define BIT_CYCLE_LATE        15
`define BIT_DSP_DONE          14
`define BIT_REACTIVE_DIR      13
`define BIT_REAL_DIR          12
`define BIT_ZERO_CROSS_LOSS   11
`define BIT_LOW_VOLTAGE       10
`define BIT_HIGH_VOLTAGE      9
`define BIT_HIGH_CURRENT      8
`define BIT_ENERGY_WRAP       2
`define BIT_CONFIG_SUM        1
`define BIT_SUPPLY_FAIL       0
`endif

// ==== meter_irq_pkg.sv ====
// types shared by both ends of the meter interrupt link
// assumes meter_irq_map.svh is on the include path
package meter_irq_pkg;
  typedef logic [15:0] word_t;
  typedef logic [7:0]  addr_t;
  typedef enum logic [1:0] {
    HOST_IDLE  = 2'b00,
    HOST_READ  = 2'b01,
    HOST_CLEAR = 2'b10
  } host_state_t;
endpackage

// ==== meter_irq_properties.sv ====
// checker for the register port and request line between device and host ends
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module meter_irq_properties (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        rvalid,
  input wire logic        irq_n
);
  logic [15:0] en_q;
  logic        mapped;
  assign mapped = addr == 8'h03 || addr == 8'h04 || addr == 8'h06;
  // shadow of the enable register so request-line checks know the mask
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) en_q <= 16'h0000;
    else if (wr && addr == 8'h06) en_q <= wdata & 16'hff07;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_en_write; wr && !rd && addr == 8'h06; endsequence
  sequence s_en_read; rd && !wr && addr == 8'h06; endsequence
  property p_read_answer; rd |=> rvalid; endproperty
  property p_no_stray_valid; !rd |=> !rvalid; endproperty
  property p_reserved_zero; rd && (addr == 8'h04 || addr == 8'h06) |=> rdata[7:3] == 5'h00;
  endproperty
  property p_unmapped_zero; rd && !mapped |=> rdata == 16'h0000; endproperty
  property p_enable_back; s_en_write ##1 s_en_read |=> rdata == ($past(wdata, 2) & 16'hff07);
  endproperty
  property p_irq_cause;
    rd && !wr && addr == 8'h04 && !$past(wr) |=> (rdata & en_q) == 16'h0000 || !irq_n;
  endproperty
  property p_irq_idle; en_q == 16'h0000 && $past(en_q) == 16'h0000 |-> irq_n; endproperty
  // a cause only falls by a host write, so without writes the line holds low
  property p_irq_holds; !irq_n && !wr && !$past(wr) && !$past(wr, 2) |=> !irq_n; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  a_no_stray_valid: assert property (p_no_stray_valid) else $error("stray answer");
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped not zero");
  a_enable_back: assert property (p_enable_back) else $error("enable readback");
  a_irq_cause: assert property (p_irq_cause) else $error("enabled cause, no request");
  a_irq_idle: assert property (p_irq_idle) else $error("request while masked");
  a_irq_holds: assert property (p_irq_holds) else $error("request dropped alone");
endmodule // meter_irq_properties
`default_nettype wire

// ==== tb_top.sv ====
// bench: device and host joined on one link, plus a second device driven here
// assumes package, interface and both design ends are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import meter_irq_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [15:0] ev = 16'h0000;
  logic [15:0] csum = 16'h0000;
  logic        fund_dis;
  int          miscompares = 0;
  int          check_count = 0;
  word_t       exp_q[$];
  word_t       host_q[$];
  word_t       hx;
  word_t       h_last;
  logic        h_seen;
  logic        h_ovr;
  logic        h_sum;
  logic        h_save;
  word_t       en;
  word_t       m;
  int          bits[11] = '{15, 14, 13, 12, 11, 10, 9, 8, 2, 1, 0};
  meter_irq_if if_a();
  meter_irq_if if_b();
  always #5 i_ref_clk = ~i_ref_clk;
  meter_irq_device i_meter_irq_device (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .bus(if_a),
    .i_cycle_late(ev[15]), .i_dsp_done(ev[14]), .i_reactive_dir_change(ev[13]),
    .i_real_dir_change(ev[12]), .i_zero_cross_loss(ev[11]), .i_low_voltage(ev[10]),
    .i_high_voltage(ev[9]), .i_high_current(ev[8]), .i_energy_wrap(ev[2]),
    .i_config_checksum(csum), .i_supply_fail(ev[0]), .o_fundamental_disable());
  meter_irq_device i_meter_irq_device_b (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .bus(if_b),
    .i_cycle_late(ev[15]), .i_dsp_done(ev[14]), .i_reactive_dir_change(ev[13]),
    .i_real_dir_change(ev[12]), .i_zero_cross_loss(ev[11]), .i_low_voltage(ev[10]),
    .i_high_voltage(ev[9]), .i_high_current(ev[8]), .i_energy_wrap(ev[2]),
    .i_config_checksum(csum), .i_supply_fail(ev[0]), .o_fundamental_disable(fund_dis));
  meter_irq_host i_meter_irq_host (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .bus(if_a),
    .i_auto_service(1'b1), .o_irq_seen(h_seen), .o_last_cause(h_last),
    .o_overrun_alert(h_ovr), .o_checksum_alert(h_sum), .o_save_state(h_save));
  meter_irq_properties i_meter_irq_properties (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .wr(if_a.wr), .rd(if_a.rd), .addr(if_a.addr), .wdata(if_a.wdata), .rdata(if_a.rdata),
    .rvalid(if_a.rvalid), .irq_n(if_a.irq_n));
  task automatic chk(input word_t seen, input word_t exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle plus event pulses; bit 1 of e stands for a checksum change
  task automatic drive(input logic w, input logic r, input addr_t a, input word_t d,
                       input logic [15:0] e, input word_t x);
    @(posedge i_ref_clk);
    #1;
    if_b.wr = w;
    if_b.rd = r;
    if_b.addr = a;
    if_b.wdata = d;
    ev = e;
    if (e[1]) csum = csum ^ (word_t'($urandom) | 16'h0001);
    if (r) exp_q.push_back(x);
    @(posedge i_ref_clk);
    #1;
    {if_b.wr, if_b.rd, ev} = '0;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // answers are matched in order; an answer nobody asked for is a mismatch
  // sampled mid-cycle, away from the edge that launches the answers
  always @(negedge i_ref_clk) begin
    if (if_b.rvalid === 1'b1 && exp_q.size() > 0) chk(if_b.rdata, exp_q.pop_front());
    else if (if_b.rvalid === 1'b1) chk(16'h0001, 16'h0000);
    if (h_seen === 1'b1 && host_q.size() > 0) begin
      hx = host_q.pop_front();
      chk(h_last, hx);
      chk(word_t'(h_ovr), word_t'(hx[15]));
      chk(word_t'(h_sum), word_t'(hx[1]));
      chk(word_t'(h_save), word_t'(hx[0]));
    end else if (h_seen === 1'b1) chk(16'h0001, 16'h0000);
  end
  initial begin
    {if_b.wr, if_b.rd, if_b.addr, if_b.wdata} = '0;
    void'($urandom(32'hb5d8));
    repeat (5) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    drive(0, 1, 8'h04, 16'h0, 16'h0, 16'h0000);
    drive(0, 1, 8'h06, 16'h0, 16'h0, 16'h0000);
    drive(1, 0, 8'h06, 16'hffff, 16'h0, 16'h0);
    drive(0, 1, 8'h06, 16'h0, 16'h0, 16'hff07);
    foreach (bits[i]) begin
      m = 16'h0001 << bits[i];
      en = word_t'($urandom) & 16'hff07;
      drive(1, 0, 8'h06, en, 16'h0, 16'h0);
      host_q.push_back(m);
      drive(0, 0, 8'h00, 16'h0, m, 16'h0);
      repeat (2) @(posedge i_ref_clk);
      #1 chk(word_t'(if_b.irq_n), word_t'((en & m) == 16'h0000));
      drive(0, 1, 8'h04, 16'h0, 16'h0, m);
      drive(1, 0, 8'h04, ~m, 16'h0, 16'h0);
      drive(0, 1, 8'h04, 16'h0, 16'h0, 16'h0000);
      chk(word_t'(if_b.irq_n), 16'h0001);
    end
    // both event cycles land before the host's read, so it sees them together
    host_q.push_back(16'h0304);
    drive(0, 0, 8'h00, 16'h0, 16'h0104, 16'h0);
    drive(1, 0, 8'h04, 16'h00fc, 16'h0200, 16'h0);
    drive(0, 1, 8'h04, 16'h0, 16'h0, 16'h0204);
    drive(0, 1, 8'h10, 16'h0, 16'h0, 16'h0000);
    drive(1, 0, 8'h03, 16'h0010, 16'h0, 16'h0);
    chk(word_t'(fund_dis), 16'h0001);
    repeat (3) @(posedge i_ref_clk);
    chk(word_t'(exp_q.size()), 16'h0000);
    chk(word_t'(host_q.size()), 16'h0000);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
